/* File: src/isdma_regs.vh */
// Register offsets, field positions and timing counts of the byte DMA engine
`ifndef ISDMA_REGS_VH
`define ISDMA_REGS_VH
`define ISDMA_OFS_STATUS_CONTROL 8'h50
`define ISDMA_OFS_OUT_NEXT 8'h70
`define ISDMA_OFS_OUT_CUR 8'h74
`define ISDMA_OFS_IN_NEXT 8'h78
`define ISDMA_OFS_IN_CUR 8'h7c
`define ISDMA_BIT_IRQ_ENABLE 31
`define ISDMA_BIT_KB_EVENT 30
`define ISDMA_BIT_LOOPBACK 17
`define ISDMA_BIT_BLOCK_RESET 16
`define ISDMA_BIT_OUT_REQ 9
`define ISDMA_BIT_OUT_ACT 8
`define ISDMA_BIT_IN_REQ 1
`define ISDMA_BIT_IN_ACT 0
`define ISDMA_PAGE_BITS 12
`define ISDMA_KB_BITS 10
`define ISDMA_RST_CTRL 32'h00010000
`define ISDMA_FRAME_NS 125000
`define ISDMA_CLK_NS 10
`define ISDMA_FRAME_CYCLES (`ISDMA_FRAME_NS / `ISDMA_CLK_NS)
`endif

/* File: src/isdma_top.v */
// Two-channel telephony byte DMA engine with register port and memory master
`timescale 1ns/10ps
`include "isdma_regs.vh"
// What this block does
// - After start, one output byte fetch happens before any link byte.
// - Far end sends a byte first; each received byte gets one answer byte.
// - A broken send/answer order is not recovered except by block reset.
// - No byte FIFO; each memory transfer finishes within one 125 us frame.
// - Each direction walks 4 KB pages starting at a software page base.
// - Interrupt after every 1 KB of input page space filled.
// - Reading status/control removes a pending interrupt.
// - Interrupt when a new page address is needed.
// - Enable bit 31 gates interrupts, resets to 0, each status/control write loads it.
// - Writing both next page registers clears a pending interrupt.
// - Kilobyte flag bit 30 sets per 1 KB, clears on status read.
// - Next page writes force the low 12 bits to zero.
// - Current address holds next location; writable for test, read whole.
// - Loopback bit 17 routes fetched bytes into the input channel.
// - Reset bit 16 resets sequencer and status flags; address registers keep their values.
// - Output request bit 9 sets on page need, clears on write, resets 1.
// - Input request bit 1 sets on page need, clears on write, resets 1.
// - Output active bit 8 marks an output transfer, read only, resets 0.
// - Input active bit 0 marks an input transfer, read only, resets 0.
module isdma_top #(
    parameter PAGE_BITS = `ISDMA_PAGE_BITS,
    parameter KB_BITS = `ISDMA_KB_BITS
) (
    input wire ref_clk_in,
    input wire rstn_in,
    input wire [7:0] reg_addr_in,
    input wire [31:0] reg_wdata_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    output reg [31:0] reg_rdata_out,
    output reg mem_rd_out,
    output reg mem_wr_out,
    output reg [31:0] mem_addr_out,
    output reg [7:0] mem_wdata_out,
    input wire [7:0] mem_rdata_in,
    input wire mem_done_in,
    input wire link_rx_valid_in,
    input wire [7:0] link_rx_data_in,
    output reg link_tx_valid_out,
    output reg [7:0] link_tx_data_out,
    output reg irq_out
);

localparam ST_IDLE = 3'h0;
localparam ST_PRIME = 3'h1;
localparam ST_WAIT_RX = 3'h2;
localparam ST_IN_WR = 3'h3;
localparam ST_OUT_RD = 3'h4;
localparam ST_HUNG = 3'h5;

reg rst_s1_ff;
reg rst_s2_ff;
reg rx_s1_ff;
reg rx_s2_ff;
reg rx_s3_ff;
reg [31:0] out_next_page_address_ff;
reg [31:0] out_current_address_ff;
reg [31:0] in_next_page_address_ff;
reg [31:0] in_current_address_ff;
reg irq_enable_ff;
reg kilobyte_event_flag_ff;
reg loopback_ff;
reg block_reset_ff;
reg out_page_request_ff;
reg in_page_request_ff;
reg output_transfer_active_ff;
reg input_transfer_active_ff;
reg out_written_ff;
reg in_written_ff;
reg irq_pending_ff;
reg [2:0] state_ff;
reg [7:0] hold_ff;
reg rx_hold_ff;

wire rst_n = rst_s2_ff;
wire eng_rst = block_reset_ff;
wire rx_rise = rx_s2_ff & rx_s3_ff & ~rx_hold_ff;
wire wr_sc = reg_wr_in && (reg_addr_in == `ISDMA_OFS_STATUS_CONTROL);
wire rd_sc = reg_rd_in && (reg_addr_in == `ISDMA_OFS_STATUS_CONTROL);
wire wr_on = reg_wr_in && (reg_addr_in == `ISDMA_OFS_OUT_NEXT);
wire wr_oc = reg_wr_in && (reg_addr_in == `ISDMA_OFS_OUT_CUR);
wire wr_in = reg_wr_in && (reg_addr_in == `ISDMA_OFS_IN_NEXT);
wire wr_ic = reg_wr_in && (reg_addr_in == `ISDMA_OFS_IN_CUR);
wire out_step = (state_ff == ST_PRIME || state_ff == ST_OUT_RD) && mem_done_in;
wire in_step = (state_ff == ST_IN_WR) && mem_done_in;
wire out_wrap = out_step && (&out_current_address_ff[PAGE_BITS-1:0]);
wire in_wrap = in_step && (&in_current_address_ff[PAGE_BITS-1:0]);
wire in_kb = in_step && (&in_current_address_ff[KB_BITS-1:0]);
wire started = out_written_ff && in_written_ff && irq_enable_ff && !eng_rst;
wire [31:0] sc_value = {irq_enable_ff, kilobyte_event_flag_ff, 12'h000, loopback_ff,
    block_reset_ff, 6'h00, out_page_request_ff, output_transfer_active_ff, 6'h00,
    in_page_request_ff, input_transfer_active_ff};

// Page-aligned copy of a written address
function [31:0] page_align;
    input [31:0] val;
    begin
        page_align = {val[31:PAGE_BITS], {PAGE_BITS{1'b0}}};
    end
endfunction

// Next address within page, or next page base at the wrap
function [31:0] advance;
    input [31:0] cur;
    input [31:0] nxt;
    input wrap;
    begin
        if (wrap) begin
            advance = nxt;
        end else begin
            advance = cur + 32'h00000001;
        end
    end
endfunction

// Reset release
always @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
        rst_s1_ff <= 1'b0;
        rst_s2_ff <= 1'b0;
    end else begin
        rst_s1_ff <= 1'b1;
        rst_s2_ff <= rst_s1_ff;
    end
end

// Link valid synchroniser, rise counted once stages agree
always @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
        rx_s1_ff <= 1'b0;
        rx_s2_ff <= 1'b0;
        rx_s3_ff <= 1'b0;
        rx_hold_ff <= 1'b0;
    end else begin
        rx_s1_ff <= link_rx_valid_in;
        rx_s2_ff <= rx_s1_ff;
        rx_s3_ff <= rx_s2_ff;
        if (rx_s2_ff == rx_s3_ff) begin
            rx_hold_ff <= rx_s3_ff;
        end
    end
end

// Registers and status
always @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
        irq_enable_ff <= 1'b0;
        loopback_ff <= 1'b0;
        block_reset_ff <= 1'b1;
        kilobyte_event_flag_ff <= 1'b0;
        out_page_request_ff <= 1'b1;
        in_page_request_ff <= 1'b1;
        out_next_page_address_ff <= 32'h00000000;
        in_next_page_address_ff <= 32'h00000000;
        out_current_address_ff <= 32'h00000000;
        in_current_address_ff <= 32'h00000000;
        out_written_ff <= 1'b0;
        in_written_ff <= 1'b0;
        irq_pending_ff <= 1'b0;
        reg_rdata_out <= 32'h00000000;
        irq_out <= 1'b0;
    end else begin
        reg_rdata_out <= 32'h00000000;
        if (reg_rd_in) begin
            if (reg_addr_in == `ISDMA_OFS_STATUS_CONTROL) begin
                reg_rdata_out <= sc_value;
            end else if (reg_addr_in == `ISDMA_OFS_OUT_NEXT) begin
                reg_rdata_out <= out_next_page_address_ff;
            end else if (reg_addr_in == `ISDMA_OFS_OUT_CUR) begin
                reg_rdata_out <= out_current_address_ff;
            end else if (reg_addr_in == `ISDMA_OFS_IN_NEXT) begin
                reg_rdata_out <= in_next_page_address_ff;
            end else if (reg_addr_in == `ISDMA_OFS_IN_CUR) begin
                reg_rdata_out <= in_current_address_ff;
            end
        end
        if (wr_sc) begin
            irq_enable_ff <= reg_wdata_in[`ISDMA_BIT_IRQ_ENABLE];
            loopback_ff <= reg_wdata_in[`ISDMA_BIT_LOOPBACK];
            block_reset_ff <= reg_wdata_in[`ISDMA_BIT_BLOCK_RESET];
        end
        if (eng_rst) begin
            // Engine logic held in reset
            kilobyte_event_flag_ff <= 1'b0;
            out_page_request_ff <= 1'b1;
            in_page_request_ff <= 1'b1;
            out_written_ff <= 1'b0;
            in_written_ff <= 1'b0;
            irq_pending_ff <= 1'b0;
        end else begin
            if (in_kb) begin
                kilobyte_event_flag_ff <= 1'b1;
            end else if (rd_sc) begin
                kilobyte_event_flag_ff <= 1'b0;
            end
            if (out_wrap) begin
                out_page_request_ff <= 1'b1;
            end else if (wr_on) begin
                out_page_request_ff <= 1'b0;
            end
            if (in_wrap) begin
                in_page_request_ff <= 1'b1;
            end else if (wr_in) begin
                in_page_request_ff <= 1'b0;
            end
            if (wr_on) begin
                out_written_ff <= 1'b1;
            end
            if (wr_in) begin
                in_written_ff <= 1'b1;
            end
            if (in_kb || in_wrap || out_wrap) begin
                irq_pending_ff <= 1'b1;
            end else if (rd_sc) begin
                irq_pending_ff <= 1'b0;
            end else if ((wr_on && in_written_ff) || (wr_in && out_written_ff)) begin
                irq_pending_ff <= 1'b0;
            end
        end
        if (wr_on) begin
            out_next_page_address_ff <= page_align(reg_wdata_in);
        end
        if (wr_in) begin
            in_next_page_address_ff <= page_align(reg_wdata_in);
        end
        if (wr_oc) begin
            out_current_address_ff <= reg_wdata_in;
        end else if (state_ff == ST_IDLE && wr_on) begin
            out_current_address_ff <= page_align(reg_wdata_in);
        end else if (out_step) begin
            out_current_address_ff <= advance(out_current_address_ff,
                out_next_page_address_ff, out_wrap);
        end
        if (wr_ic) begin
            in_current_address_ff <= reg_wdata_in;
        end else if (state_ff == ST_IDLE && wr_in) begin
            in_current_address_ff <= page_align(reg_wdata_in);
        end else if (in_step) begin
            in_current_address_ff <= advance(in_current_address_ff,
                in_next_page_address_ff, in_wrap);
        end
        irq_out <= irq_enable_ff && !eng_rst && (irq_pending_ff || kilobyte_event_flag_ff ||
            out_page_request_ff || in_page_request_ff);
    end
end

// Transfer sequencer
always @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
        state_ff <= ST_IDLE;
        hold_ff <= 8'h00;
        mem_rd_out <= 1'b0;
        mem_wr_out <= 1'b0;
        mem_addr_out <= 32'h00000000;
        mem_wdata_out <= 8'h00;
        link_tx_valid_out <= 1'b0;
        link_tx_data_out <= 8'h00;
        output_transfer_active_ff <= 1'b0;
        input_transfer_active_ff <= 1'b0;
    end else if (eng_rst) begin
        state_ff <= ST_IDLE;
        mem_rd_out <= 1'b0;
        mem_wr_out <= 1'b0;
        link_tx_valid_out <= 1'b0;
        output_transfer_active_ff <= 1'b0;
        input_transfer_active_ff <= 1'b0;
    end else begin
        link_tx_valid_out <= 1'b0;
        case (state_ff)
            ST_IDLE: begin
                if (started) begin
                    state_ff <= ST_PRIME;
                    mem_rd_out <= 1'b1;
                    mem_addr_out <= out_current_address_ff;
                    output_transfer_active_ff <= 1'b1;
                end
            end
            ST_PRIME: begin
                if (mem_done_in) begin
                    mem_rd_out <= 1'b0;
                    hold_ff <= mem_rdata_in;
                    output_transfer_active_ff <= 1'b0;
                    state_ff <= ST_WAIT_RX;
                end else if (rx_rise) begin
                    state_ff <= ST_HUNG;
                end
            end
            ST_WAIT_RX: begin
                if (rx_rise || loopback_ff) begin
                    link_tx_valid_out <= !loopback_ff;
                    link_tx_data_out <= hold_ff;
                    mem_wr_out <= 1'b1;
                    mem_addr_out <= in_current_address_ff;
                    mem_wdata_out <= loopback_ff ? hold_ff : link_rx_data_in;
                    input_transfer_active_ff <= 1'b1;
                    state_ff <= ST_IN_WR;
                end
            end
            ST_IN_WR: begin
                if (rx_rise && !loopback_ff) begin
                    state_ff <= ST_HUNG;
                end else if (mem_done_in) begin
                    mem_wr_out <= 1'b0;
                    input_transfer_active_ff <= 1'b0;
                    mem_rd_out <= 1'b1;
                    mem_addr_out <= out_current_address_ff;
                    output_transfer_active_ff <= 1'b1;
                    state_ff <= ST_OUT_RD;
                end
            end
            ST_OUT_RD: begin
                if (rx_rise && !loopback_ff) begin
                    state_ff <= ST_HUNG;
                end else if (mem_done_in) begin
                    mem_rd_out <= 1'b0;
                    hold_ff <= mem_rdata_in;
                    output_transfer_active_ff <= 1'b0;
                    state_ff <= ST_WAIT_RX;
                end
            end
            ST_HUNG: begin
                mem_rd_out <= 1'b0;
                mem_wr_out <= 1'b0;
            end
            default: begin
                mem_rd_out <= 1'b0;
                mem_wr_out <= 1'b0;
                state_ff <= ST_HUNG;
            end
        endcase
    end
end

endmodule

/* File: verif/isdma_link_model.sv */
// Far-end telephony controller model on the byte link
`timescale 1ns/10ps
module isdma_link_model (
    input wire clk_in,
    input wire go_in,
    input wire [7:0] byte_in,
    input wire [3:0] gap_in,
    input wire tx_valid_in,
    output reg rx_valid_out,
    output reg [7:0] rx_data_out,
    output reg [15:0] n_done_out
);
    initial begin
        rx_valid_out = 1'b0;
        rx_data_out = 8'h00;
        n_done_out = 16'h0000;
    end
    always begin
        @(posedge clk_in);
        if (go_in) begin
            repeat (gap_in) @(posedge clk_in);
            rx_data_out <= byte_in;
            rx_valid_out <= 1'b1;
            do @(posedge clk_in); while (!tx_valid_in);
            rx_valid_out <= 1'b0;
            rx_data_out <= ~rx_data_out;
            n_done_out <= n_done_out + 16'h0001;
        end
    end
endmodule

/* File: verif/isdma_top_properties.sv */
// Port-level assertions of the byte DMA engine
`timescale 1ns/10ps
module isdma_checker (
    input wire ref_clk_in,
    input wire rstn_in,
    input wire [7:0] reg_addr_in,
    input wire [31:0] reg_wdata_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    input wire [31:0] reg_rdata_out,
    input wire mem_rd_out,
    input wire mem_wr_out,
    input wire [31:0] mem_addr_out,
    input wire [7:0] mem_wdata_out,
    input wire mem_done_in,
    input wire link_tx_valid_out,
    input wire irq_out
);
    reg en_ff;
    reg rst_ff;
    reg [2:0] rsh_ff;
    wire ctl_wr = reg_wr_in && reg_addr_in == 8'h50;
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rstn_in);
    // Shadow of enable and block reset bits
    always @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            en_ff <= 1'b0;
            rst_ff <= 1'b1;
            rsh_ff <= 3'h7;
        end else begin
            if (ctl_wr) begin
                en_ff <= reg_wdata_in[31];
                rst_ff <= reg_wdata_in[16];
            end
            rsh_ff <= {rsh_ff[1:0], rst_ff};
        end
    end
    a_irq_gated: assert property (irq_out |-> en_ff || $past(en_ff))
        else $error("interrupt while disabled");
    a_page_align: assert property (reg_rd_in && (reg_addr_in == 8'h70 ||
        reg_addr_in == 8'h78) |=> reg_rdata_out[11:0] == 12'h000)
        else $error("next page low bits not zero");
    a_req_after_rst: assert property (reg_rd_in && reg_addr_in == 8'h50 && rst_ff &&
        (&rsh_ff) |=> reg_rdata_out[9] && reg_rdata_out[1] && !reg_rdata_out[8] && !reg_rdata_out[0])
        else $error("status wrong in block reset");
    a_tx_pulse: assert property (link_tx_valid_out |=> !link_tx_valid_out)
        else $error("answer byte longer than one cycle");
    a_tx_with_wr: assert property (link_tx_valid_out |-> $rose(mem_wr_out))
        else $error("answer byte without input write");
    a_rd_hold: assert property (mem_rd_out && !mem_done_in && !rst_ff |=>
        mem_rd_out && $stable(mem_addr_out))
        else $error("fetch dropped early");
    a_wr_hold: assert property (mem_wr_out && !mem_done_in && !rst_ff |=>
        mem_wr_out && $stable(mem_addr_out) && $stable(mem_wdata_out))
        else $error("store dropped early");
    a_blk_idle: assert property (rst_ff && rsh_ff[1:0] == 2'h3 |->
        !mem_rd_out && !mem_wr_out && !link_tx_valid_out)
        else $error("activity in block reset");
    c_answer: cover property (link_tx_valid_out);
    c_store: cover property (mem_wr_out && mem_done_in);
    c_irq: cover property (irq_out);
endmodule
bind isdma_top isdma_checker i_chk (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .mem_rd_out(mem_rd_out),
    .mem_wr_out(mem_wr_out), .mem_addr_out(mem_addr_out), .mem_wdata_out(mem_wdata_out),
    .mem_done_in(mem_done_in), .link_tx_valid_out(link_tx_valid_out), .irq_out(irq_out));

/* File: verif/test_isdn_byte_dma.sv */
// Self-checking bench of the byte DMA engine
`timescale 1ns/10ps
module test_isdn_byte_dma;
    logic ref_clk_in = 0;
    logic rstn_in = 0;
    logic [7:0] reg_addr_in = 0;
    logic [31:0] reg_wdata_in = 0;
    logic reg_wr_in = 0, reg_rd_in = 0, mem_done_in = 0, go = 0;
    logic [7:0] mem_rdata_in = 0;
    wire link_rx_valid_in, mem_rd_out, mem_wr_out, link_tx_valid_out, irq_out;
    wire [7:0] link_rx_data_in, mem_wdata_out, link_tx_data_out;
    wire [31:0] reg_rdata_out, mem_addr_out;
    wire [15:0] n_done;
    logic [31:0] lfsr = 32'hab5019a8, v, eo, ei, nin, ob, ib;
    logic [7:0] rxq[$], outq[$];
    logic [1:0] lat = 0;
    logic first = 0, loop = 0, rxp = 0;
    int n_errors = 0, n_compared = 0, cyc = 0, nwr = 0;
    always #5 ref_clk_in = ~ref_clk_in;
    isdma_top i_dut (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out), .mem_rd_out(mem_rd_out), .mem_wr_out(mem_wr_out),
        .mem_addr_out(mem_addr_out), .mem_wdata_out(mem_wdata_out),
        .mem_rdata_in(mem_rdata_in), .mem_done_in(mem_done_in),
        .link_rx_valid_in(link_rx_valid_in), .link_rx_data_in(link_rx_data_in),
        .link_tx_valid_out(link_tx_valid_out), .link_tx_data_out(link_tx_data_out),
        .irq_out(irq_out));
    isdma_link_model i_far (.clk_in(ref_clk_in), .go_in(go), .byte_in(lfsr[7:0]),
        .gap_in({1'b0, lfsr[10:8]} + 4'd8), .tx_valid_in(link_tx_valid_out),
        .rx_valid_out(link_rx_valid_in), .rx_data_out(link_rx_data_in), .n_done_out(n_done));
    function [31:0] lfsr_next(input [31:0] s);
        lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function [7:0] mb(input [31:0] a);
        mb = a[7:0] ^ a[15:8] ^ 8'h3c;
    endfunction
    task chk(input [31:0] s, input [31:0] e);
        n_compared++;
        if (s !== e) begin
            n_errors++;
            $display("mismatch at %0t: saw %h want %h", $time, s, e);
        end
    endtask
    task test_done;
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task wr(input [7:0] a, input [31:0] d);
        @(posedge ref_clk_in);
        reg_wr_in <= 1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge ref_clk_in);
        reg_wr_in <= 0;
    endtask
    task rd(input [7:0] a);
        @(posedge ref_clk_in);
        reg_rd_in <= 1;
        reg_addr_in <= a;
        @(posedge ref_clk_in);
        reg_rd_in <= 0;
        #1 v = reg_rdata_out;
    endtask
    task run(input int n);
        repeat (n) begin
            go <= 1;
            @(posedge ref_clk_in);
            while (!link_rx_valid_in) @(posedge ref_clk_in);
            go <= 0;
            v = n_done;
            while (n_done == v[15:0]) @(posedge ref_clk_in);
        end
        repeat (4) @(posedge ref_clk_in);
        for (int k = 0; k < 60 && (mem_rd_out || mem_wr_out); k++) @(posedge ref_clk_in);
    endtask
    // Memory slave and reference model of both channels
    always @(posedge ref_clk_in) begin
        lfsr <= lfsr_next(lfsr);
        mem_done_in <= 0;
        rxp <= link_rx_valid_in;
        cyc++;
        if (link_rx_valid_in && !rxp) rxq.push_back(link_rx_data_in);
        if (link_tx_valid_out) begin
            chk(loop, 0);
            chk(link_tx_data_out, outq.pop_front());
        end
        if ((mem_rd_out || mem_wr_out) && !mem_done_in) begin
            if (lat != 0) lat <= lat - 1;
            else begin
                mem_done_in <= 1;
                lat <= lfsr[13:12];
                if (first) chk(mem_rd_out, 1);
                first = 0;
                if (mem_rd_out) begin
                    chk(mem_addr_out, eo);
                    eo = eo + 1;
                    mem_rdata_in <= mb(mem_addr_out);
                    outq.push_back(mb(mem_addr_out));
                end else begin
                    chk(mem_addr_out, ei);
                    chk(mem_wdata_out, loop ? outq.pop_front() : rxq.pop_front());
                    ei = ei + 1;
                    if (ei[11:0] == 12'h000) ei = nin;
                    nwr++;
                end
            end
        end
        if (cyc == 20000) begin
            n_errors++;
            $display("mismatch at %0t: timeout", $time);
            test_done;
        end
    end
    initial begin
        repeat (10) @(posedge ref_clk_in);
        rstn_in <= 1;
        repeat (4) @(posedge ref_clk_in);
        rd(8'h50); chk(v, 32'h00010202);
        rd(8'h60); chk(v, 0);
        chk(irq_out, 0);
        $display("reset test done");
        ob = lfsr & 32'hfffff000;
        ib = ob ^ 32'h00100000;
        wr(8'h50, 32'h80000303);
        rd(8'h50); chk(v, 32'h80000202);
        chk(irq_out, 1);
        eo = ob; ei = ib; nin = ib; first = 1;
        wr(8'h70, ob | 32'h5a5);
        wr(8'h78, ib | 32'hfff);
        rd(8'h70); chk(v, ob);
        chk(irq_out, 0);
        rd(8'h78); chk(v, ib);
        run(8);
        rd(8'h74); chk(v, eo);
        rd(8'h7c); chk(v, ei);
        $display("start and traffic test done");
        ei = ib + 32'h3fd; wr(8'h7c, ei); run(5);
        chk(irq_out, 1);
        rd(8'h50); chk(v[30], 1);
        repeat (2) @(posedge ref_clk_in);
        chk(irq_out, 0);
        rd(8'h50); chk(v[30], 0);
        ei = ib + 32'hffe; wr(8'h7c, ei); run(4);
        rd(8'h50); chk(v[1], 1);
        chk(irq_out, 1);
        rd(8'h7c); chk(v, ei);
        wr(8'h70, ob); wr(8'h78, ib); repeat (2) @(posedge ref_clk_in);
        chk(irq_out, 0);
        $display("kilobyte and page test done");
        wr(8'h50, 32'h00010000); repeat (3) @(posedge ref_clk_in);
        rd(8'h50); chk(v, 32'h00010202);
        wr(8'h50, 32'h80030000);
        wr(8'h50, 32'h80020000);
        outq.delete(); rxq.delete();
        loop = 1; first = 1; eo = ob ^ 32'h00200000; ei = ib ^ 32'h00200000; nin = ei;
        wr(8'h70, eo); wr(8'h78, ei);
        while (nwr < 40) @(posedge ref_clk_in);
        wr(8'h50, 32'h00010000); repeat (4) @(posedge ref_clk_in);
        chk(mem_rd_out | mem_wr_out, 0);
        $display("loopback test done");
        test_done;
    end
endmodule
